/* File: pkg/ssc_pkg.sv */
// Constants and types of the switching clock source select block
// ============================================================
`default_nettype none
package ssc_pkg;
	// ============================================================
	// Timing, all figures in kHz and derived cycle counts
	localparam int HCLK_KHZ = 40000;
	localparam int BASE_KHZ = 8000;
	localparam int EXT_MIN_KHZ = 200;
	localparam int EXT_MAX_KHZ = 2000;
	localparam int BASE_DIV = HCLK_KHZ / BASE_KHZ;
	// Longest legal period rounds down, shortest rounds up
	localparam int EXT_MAX_PER = HCLK_KHZ / EXT_MIN_KHZ;
	localparam int EXT_MIN_PER = (HCLK_KHZ + EXT_MAX_KHZ - 1) / EXT_MAX_KHZ;
	localparam int DET_WIN = 4 * EXT_MAX_PER;
	localparam int BOOT_CYC = 4;
	localparam int LOCK_EDGES = 2;

	// ============================================================
	// Divider values
	localparam logic [5:0] N_MIN = 6'h04;
	localparam logic [5:0] N_MAX = 6'h28;
	localparam logic [5:0] N_MASTER = 6'h14;
	localparam logic [5:0] N_LOW = 6'h28;
	localparam logic [5:0] N_OPEN = 6'h14;
	localparam logic [5:0] N_HIGH = 6'h08;
	localparam int RES_LAST = 20;
	// Resistor index to divider, 200 kHz up to 2000 kHz
	localparam logic [5:0] RES_N [0:20] = '{
		6'h28, 6'h24, 6'h21, 6'h1E, 6'h1B, 6'h19, 6'h16, 6'h14,
		6'h13, 6'h11, 6'h0F, 6'h0E, 6'h0D, 6'h0C, 6'h0B, 6'h09,
		6'h08, 6'h07, 6'h06, 6'h05, 6'h04};

	// ============================================================
	// Register map
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_FREQ = 8'h08;
	localparam logic [7:0] REG_STRAP = 8'h0C;
	localparam int CTRL_OVR_BIT = 0;
	localparam int CTRL_N_LSB = 8;
	localparam int STAT_RUN_BIT = 0;
	localparam int STAT_LOCK_BIT = 1;
	localparam int STAT_MODE_LSB = 4;
	localparam int STAT_PER_LSB = 8;
	localparam int STRAP_CODE_LSB = 8;
	localparam logic [5:0] CTRL_N_RST = 6'h14;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	// ============================================================
	// Pin levels and controller states
	typedef enum logic [1:0] {
		LVL_LOW = 2'h0,
		LVL_OPEN = 2'h1,
		LVL_HIGH = 2'h2,
		LVL_RES = 2'h3
	} ssc_level_type;

	typedef enum logic [3:0] {
		ST_BOOT = 4'h1,
		ST_IDLE = 4'h2,
		ST_DETECT = 4'h4,
		ST_RUN = 4'h8
	} ssc_state_type;
endpackage : ssc_pkg
`default_nettype wire

/* File: design/ssc_link_toggle.sv */
// Link-domain edge catcher on the shared clock pin
`default_nettype none
module ssc_link_toggle import ssc_pkg::*; (
	input wire logic sync_clk,
	input wire logic hresetn,
	output logic edge_tog
);
	typedef struct packed {
		logic tog;
	} ssc_link_type;

	ssc_link_type s_reg;
	ssc_link_type s_next;

	// ============================================================
	// One toggle per rising edge of the incoming clock
	always_comb begin
		s_next = s_reg;
		s_next.tog = ~s_reg.tog;
	end

	// Link-side register
	always_ff @(posedge sync_clk or negedge hresetn) begin
		if (!hresetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign edge_tog = s_reg.tog;
endmodule : ssc_link_toggle
`default_nettype wire

/* File: design/ssc_clock_select.sv */
// Switching clock source select with AHB-Lite register slave
`default_nettype none
module ssc_clock_select import ssc_pkg::*; #(
	parameter int MIN_PER = EXT_MIN_PER,
	parameter int MAX_PER = EXT_MAX_PER
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic en_pin,
	input wire logic [1:0] cfg_strap,
	input wire logic [1:0] sync_strap,
	input wire logic [4:0] frequency_set_resistor,
	input wire logic sync_clk,
	output logic sync_out,
	output logic sync_oe,
	output logic sw_clk,
	output logic locked
);
	typedef struct packed {
		logic en_s1, en_s2, en_s3;
		logic [1:0] cfg_s1, cfg_s2;
		logic [1:0] strap_s1, strap_s2;
		logic [4:0] res_s1, res_s2;
		logic tog_s1, tog_s2, tog_s3;
		ssc_state_type state;
		logic [2:0] boot_cnt;
		logic [1:0] mode;
		logic [1:0] strap_code;
		logic [5:0] strap_n;
		logic [7:0] per_cnt;
		logic [7:0] last_per;
		logic [1:0] valid_cnt;
		logic [9:0] det_cnt;
		logic locked;
		logic [7:0] div_cnt;
		logic sw_clk;
		logic sync_out;
		logic sync_oe;
		logic ovr_en;
		logic [5:0] ovr_n;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] hrdata;
		logic [15:0] freq_khz;
		logic hreadyout;
	} ssc_st_type;

	localparam ssc_st_type ST_RST = '{state: ST_BOOT, per_cnt: 8'hFF,
		ovr_n: CTRL_N_RST, hreadyout: 1'b1, last_per: 8'hFF,
		freq_khz: 16'h0190, default: '0};

	ssc_st_type s_reg;
	ssc_st_type s_next;
	logic edge_tog;
	logic edge_ev;
	logic en_rise;
	logic per_ok;
	logic [5:0] act_n;
	logic [7:0] period;
	logic [7:0] div_nx;
	logic addr_ph;

	// ============================================================
	// Link-domain edge catcher
	ssc_link_toggle u_link (
		.sync_clk(sync_clk),
		.hresetn(hresetn),
		.edge_tog(edge_tog)
	);

	// Divider clamp for software writes
	function automatic logic [5:0] clamp_n(input logic [5:0] v);
		clamp_n = (v < N_MIN) ? N_MIN : ((v > N_MAX) ? N_MAX : v);
	endfunction : clamp_n

	// Strap level or resistor to divider
	function automatic logic [5:0] strap_to_n(input logic [1:0] code,
		input logic [4:0] idx);
		logic [4:0] k;
		k = (int'(idx) > RES_LAST) ? 5'(RES_LAST) : idx;
		unique case (code)
			LVL_LOW: strap_to_n = N_LOW;
			LVL_OPEN: strap_to_n = N_OPEN;
			LVL_HIGH: strap_to_n = N_HIGH;
			default: strap_to_n = RES_N[k];
		endcase
	endfunction : strap_to_n

	// ============================================================
	// Next-state logic
	always_comb begin
		s_next = s_reg;
		// Pin and crossing synchronisers
		s_next.en_s1 = en_pin;
		s_next.en_s2 = s_reg.en_s1;
		s_next.en_s3 = s_reg.en_s2;
		s_next.cfg_s1 = cfg_strap;
		s_next.cfg_s2 = s_reg.cfg_s1;
		s_next.strap_s1 = sync_strap;
		s_next.strap_s2 = s_reg.strap_s1;
		s_next.res_s1 = frequency_set_resistor;
		s_next.res_s2 = s_reg.res_s1;
		s_next.tog_s1 = edge_tog;
		s_next.tog_s2 = s_reg.tog_s1;
		s_next.tog_s3 = s_reg.tog_s2;
		edge_ev = s_reg.tog_s2 ^ s_reg.tog_s3;
		en_rise = s_reg.en_s2 & ~s_reg.en_s3;

		// Period measure; out of range means absent
		per_ok = (int'(s_reg.per_cnt) >= MIN_PER) &&
			(int'(s_reg.per_cnt) <= MAX_PER);
		if (edge_ev) begin
			s_next.per_cnt = 8'h01;
			s_next.last_per = s_reg.per_cnt;
			if (!per_ok) begin
				s_next.valid_cnt = 2'h0;
			end else if (int'(s_reg.valid_cnt) < LOCK_EDGES) begin
				s_next.valid_cnt = s_reg.valid_cnt + 2'h1;
			end
		end else if (s_reg.per_cnt != 8'hFF) begin
			s_next.per_cnt = s_reg.per_cnt + 8'h01;
		end

		// Active divider: master preset, software, or strap
		if (s_reg.mode == LVL_HIGH) begin
			act_n = N_MASTER;
		end else if (s_reg.ovr_en) begin
			act_n = s_reg.ovr_n;
		end else begin
			act_n = s_reg.strap_n;
		end

		// Controller
		unique case (s_reg.state)
			ST_BOOT: begin
				s_next.boot_cnt = s_reg.boot_cnt + 3'h1;
				if (int'(s_reg.boot_cnt) == BOOT_CYC - 1) begin
					// Straps caught once, never again
					s_next.mode = s_reg.cfg_s2;
					s_next.strap_code = s_reg.strap_s2;
					s_next.strap_n = strap_to_n(s_reg.strap_s2, s_reg.res_s2);
					s_next.state = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (en_rise) begin
					s_next.locked = 1'b0;
					s_next.div_cnt = 8'h00;
					if (s_reg.mode == LVL_HIGH) begin
						s_next.state = ST_RUN;
					end else begin
						s_next.state = ST_DETECT;
						s_next.det_cnt = 10'h000;
						s_next.valid_cnt = 2'h0;
					end
				end
			end
			ST_DETECT: begin
				s_next.det_cnt = s_reg.det_cnt + 10'h001;
				if (!s_reg.en_s2) begin
					s_next.state = ST_IDLE;
				end else if (int'(s_reg.valid_cnt) == LOCK_EDGES) begin
					s_next.state = ST_RUN;
					s_next.locked = 1'b1;
				end else if (int'(s_reg.det_cnt) == DET_WIN - 1) begin
					s_next.state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!s_reg.en_s2) begin
					s_next.state = ST_IDLE;
					s_next.locked = 1'b0;
				end else if (s_reg.locked && edge_ev && !per_ok) begin
					s_next.locked = 1'b0;
				end
			end
		endcase

		// Switching clock divider, restarted on incoming rise when locked
		period = s_reg.locked ? s_reg.last_per :
			8'(BASE_DIV * int'(act_n));
		if (s_reg.locked && edge_ev) begin
			div_nx = 8'h00;
		end else if (s_reg.div_cnt >= period - 8'h01) begin
			div_nx = 8'h00;
		end else begin
			div_nx = s_reg.div_cnt + 8'h01;
		end
		s_next.div_cnt = (s_reg.state == ST_RUN) ? div_nx : 8'h00;
		s_next.sw_clk = (s_reg.state == ST_RUN) &&
			(div_nx < {1'b0, period[7:1]});

		// Shared pin drives only in master mode
		s_next.sync_oe = (s_next.mode == LVL_HIGH) &&
			(s_next.state != ST_BOOT);
		s_next.sync_out = s_next.sync_oe & s_next.sw_clk;

		// Quantized frequency as produced
		if (s_reg.locked) begin
			s_next.freq_khz = 16'(HCLK_KHZ / int'(s_reg.last_per));
		end else if (act_n != 6'h00) begin
			// Divider is zero only during startup
			s_next.freq_khz = 16'(BASE_KHZ / int'(act_n));
		end

		// AHB-Lite slave, zero wait states, always OKAY
		s_next.hreadyout = 1'b1;
		addr_ph = hsel && htrans[1] && hready;
		s_next.wr_pend = addr_ph && hwrite && (hsize == HSIZE_WORD);
		s_next.wr_addr = haddr;
		s_next.hrdata = 32'h0000_0000;
		if (addr_ph && !hwrite) begin
			unique case (haddr)
				REG_CTRL: begin
					s_next.hrdata[CTRL_OVR_BIT] = s_reg.ovr_en;
					s_next.hrdata[CTRL_N_LSB +: 6] = s_reg.ovr_n;
				end
				REG_STATUS: begin
					s_next.hrdata[STAT_RUN_BIT] = s_reg.state == ST_RUN;
					s_next.hrdata[STAT_LOCK_BIT] = s_reg.locked;
					s_next.hrdata[STAT_MODE_LSB +: 2] = s_reg.mode;
					s_next.hrdata[STAT_PER_LSB +: 8] = period;
				end
				REG_FREQ: s_next.hrdata[15:0] = s_reg.freq_khz;
				REG_STRAP: begin
					s_next.hrdata[5:0] = s_reg.strap_n;
					s_next.hrdata[STRAP_CODE_LSB +: 2] = s_reg.strap_code;
				end
				default: s_next.hrdata = 32'h0000_0000;
			endcase
		end
		// Write data phase
		if (s_reg.wr_pend && s_reg.wr_addr == REG_CTRL) begin
			s_next.ovr_en = hwdata[CTRL_OVR_BIT];
			s_next.ovr_n = clamp_n(hwdata[CTRL_N_LSB +: 6]);
		end
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_reg <= ST_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from the state register
	assign hreadyout = s_reg.hreadyout;
	assign hresp = 1'b0 & s_reg.hreadyout;
	assign hrdata = s_reg.hrdata;
	assign sync_out = s_reg.sync_out;
	assign sync_oe = s_reg.sync_oe;
	assign sw_clk = s_reg.sw_clk;
	assign locked = s_reg.locked;

	// ============================================================
	// Checks
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	chk_strap_frozen: assert property (
		s_reg.state != ST_BOOT |=> $stable(s_reg.strap_n)
	) else $error("strap divider changed after startup");

	chk_auto_detect: assert property (
		s_reg.state == ST_IDLE && en_rise && s_reg.mode != LVL_HIGH
		|=> s_reg.state == ST_DETECT
	) else $error("enable did not start clock detection");

	chk_master_skip: assert property (
		s_reg.state == ST_IDLE && en_rise && s_reg.mode == LVL_HIGH
		|=> s_reg.state == ST_RUN && !s_reg.locked
	) else $error("master mode checked for incoming clock");

	chk_master_drive: assert property (
		s_reg.state == ST_RUN && s_reg.mode == LVL_HIGH
		|-> sync_oe && sync_out == sw_clk && act_n == N_MASTER
	) else $error("master mode not driving preset clock");

	chk_input_quiet: assert property (
		s_reg.mode != LVL_HIGH |-> !sync_oe
	) else $error("shared pin driven while an input");

	chk_lock_phase: assert property (
		s_reg.state == ST_RUN && s_reg.locked && edge_ev && per_ok &&
		s_reg.en_s2 |=> s_reg.div_cnt == 8'h00 && sw_clk
	) else $error("switching clock not aligned to incoming rise");

	chk_n_bounds: assert property (
		s_reg.state == ST_RUN |-> act_n >= N_MIN && act_n <= N_MAX
	) else $error("divider outside legal range");

	chk_strap_level: assert property (
		s_reg.state != ST_BOOT && s_reg.strap_code == LVL_LOW
		|-> s_reg.strap_n == N_LOW
	) else $error("low strap not mapped to lowest frequency");

	chk_res_top: assert property (
		$fell(s_reg.state == ST_BOOT) && s_reg.strap_code == LVL_RES &&
		int'(s_reg.res_s2) >= RES_LAST |-> s_reg.strap_n == N_MIN
	) else $error("largest resistor not mapped to top frequency");

	chk_bad_period: assert property (
		edge_ev && !per_ok |=> s_reg.valid_cnt == 2'h0 ##1 !$rose(locked)
	) else $error("out of range clock counted as valid");

	chk_freq_read: assert property (
		s_reg.state == ST_RUN && !s_reg.locked && $stable(act_n)
		|=> int'(s_reg.freq_khz) == BASE_KHZ / int'($past(act_n))
	) else $error("read back frequency not the divider result");

	cov_lock: cover property (s_reg.state == ST_DETECT ##1 $rose(locked));
	cov_fallback: cover property (
		s_reg.state == ST_DETECT ##1 s_reg.state == ST_RUN && !locked);
	cov_master: cover property (s_reg.state == ST_RUN && sync_oe);
	cov_override: cover property (s_reg.ovr_en && s_reg.state == ST_RUN);
endmodule : ssc_clock_select
`default_nettype wire

/* File: test/ssc_sync_source.sv */
// Behavioural neighbour converter driving the shared clock line
`default_nettype none
module ssc_sync_source (
	input wire logic run,
	input wire logic slow,
	input wire logic line_busy,
	output logic clk_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ============================================================
	// Clock source
	// Runs only while run is set and the line is not busy, stands low otherwise
	initial begin
		clk_out = 1'b0;
		#7;
		forever begin
			if (run && !line_busy) begin
				#(slow ? 200 : 40) clk_out = 1'b1;
				#(slow ? 200 : 40) clk_out = 1'b0;
			end else begin
				#5;
			end
		end
	end
endmodule : ssc_sync_source
`default_nettype wire

/* File: test/ssc_clock_select_test.sv */
// Self-checking bench of the switching clock source select block
`default_nettype none
module ssc_clock_select_test import ssc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// ============================================================
	// Signals
	logic hclk, hresetn, hsel, hwrite, en_pin, run, slow, rd_dp = 1'b0;
	logic [7:0] haddr;
	logic [1:0] htrans, cfg_strap, sync_strap;
	logic [2:0] hsize, sz = HSIZE_WORD;
	logic [31:0] hwdata, hrdata, rnd = 32'h523d;
	logic [4:0] res_idx, idx;
	logic hreadyout, hresp, sync_out, sync_oe, sw_clk, locked;
	logic ext_clk, sync_line;
	logic [31:0] exp_q[$];
	int err_total = 0, total_checks = 0;
	logic [5:0] nv [0:2];

	// ============================================================
	// Design, partner and shared line
	assign sync_line = sync_oe ? sync_out : ext_clk;
	ssc_clock_select #(.MIN_PER(2), .MAX_PER(8)) dut (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .en_pin(en_pin), .cfg_strap(cfg_strap),
		.sync_strap(sync_strap), .frequency_set_resistor(res_idx),
		.sync_clk(sync_line), .sync_out(sync_out), .sync_oe(sync_oe),
		.sw_clk(sw_clk), .locked(locked));
	ssc_sync_source partner (.run(run), .slow(slow), .line_busy(sync_oe),
		.clk_out(ext_clk));

	// ============================================================
	// Clock, helpers
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs

	function automatic logic [5:0] strap_n(input logic [1:0] s,
		input logic [4:0] i);
		case (s)
			2'h0: return N_LOW;
			2'h1: return N_OPEN;
			2'h2: return N_HIGH;
			default: return RES_N[i];
		endcase
	endfunction : strap_n

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : check

	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : test_done

	// One single AHB transfer; reads note their expected data
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [31:0] e);
		if (!w)
			exp_q.push_back(e);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		hsize <= sz;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask : bus

	task automatic do_reset(input logic [1:0] c, input logic [1:0] s,
		input logic [4:0] i);
		hresetn <= 1'b0;
		en_pin <= 1'b0;
		cfg_strap <= c;
		sync_strap <= s;
		res_idx <= i;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (12) @(posedge hclk);
	endtask : do_reset

	task automatic en_wait(input int c);
		en_pin <= 1'b1;
		repeat (c) @(posedge hclk);
	endtask : en_wait

	task automatic wait_lock();
		for (int i = 0; i < 2000 && locked !== 1'b1; i++)
			@(posedge hclk);
	endtask : wait_lock

	// Counts hclk cycles of one full switching period
	task automatic per(input int e);
		int n;
		n = 0;
		do @(posedge hclk); while (sw_clk !== 1'b0);
		do @(posedge hclk); while (sw_clk !== 1'b1);
		do begin @(posedge hclk); n++; end while (sw_clk !== 1'b0);
		do begin @(posedge hclk); n++; end while (sw_clk !== 1'b1);
		check(32'(n), 32'(e));
	endtask : per

	// ============================================================
	// Read data monitor, oldest note first
	always @(posedge hclk) begin
		if (rd_dp && hreadyout === 1'b1)
			check(hrdata, exp_q.pop_front());
		rd_dp <= hsel && htrans[1] && !hwrite && hreadyout;
	end

	// ============================================================
	// Watchdog
	initial begin
		repeat (60000) @(posedge hclk);
		err_total++;
		test_done();
	end

	// ============================================================
	// Main sequence
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = HSIZE_WORD;
		hwdata = 32'h0;
		en_pin = 1'b0;
		cfg_strap = 2'h1;
		sync_strap = 2'h1;
		res_idx = 5'h00;
		run = 1'b0;
		slow = 1'b0;
		rnd = xs(rnd);
		idx = 5'(rnd % 21);
		// Reset values, refusals and strap latch
		do_reset(2'h1, 2'h3, idx);
		check(hresp, 32'h0);
		check(hreadyout, 32'h1);
		bus(0, REG_CTRL, 0, 32'(CTRL_N_RST) << CTRL_N_LSB);
		bus(0, REG_STRAP, 0, (32'h3 << STRAP_CODE_LSB) | RES_N[idx]);
		bus(1, 8'h10, 32'hFFFF, 0);
		bus(0, 8'h10, 0, 32'h0);
		sz = 3'h0;
		bus(1, REG_CTRL, 32'h0801, 0);
		sz = HSIZE_WORD;
		bus(0, REG_CTRL, 0, 32'(CTRL_N_RST) << CTRL_N_LSB);
		sync_strap <= 2'h0;
		res_idx <= ~idx;
		bus(0, REG_STRAP, 0, (32'h3 << STRAP_CODE_LSB) | RES_N[idx]);
		// Software divider clamped to its range
		rnd = xs(rnd);
		nv[0] = 6'h03;
		nv[1] = 6'h29;
		nv[2] = 6'(4 + rnd % 37);
		for (int k = 0; k < 3; k++) begin
			bus(1, REG_CTRL, (32'(nv[k]) << CTRL_N_LSB) | 32'h1, 0);
			bus(0, REG_CTRL, 0, (32'(nv[k] < N_MIN ? N_MIN :
				nv[k] > N_MAX ? N_MAX : nv[k]) << CTRL_N_LSB) | 32'h1);
		end
		bus(1, REG_CTRL, (32'h7 << CTRL_N_LSB) | 32'h1, 0);
		en_wait(1000);
		bus(0, REG_FREQ, 0, 32'(BASE_KHZ / 7));
		per(5 * 7);
		en_pin <= 1'b0;
		repeat (20) @(posedge hclk);
		check(sw_clk, 32'h0);
		// Strap frequencies with no incoming clock
		for (int s = 0; s < 4; s++) begin
			rnd = xs(rnd);
			idx = 5'(rnd % 21);
			do_reset(2'h1, 2'(s), idx);
			bus(0, REG_STRAP, 0, (32'(s) << STRAP_CODE_LSB)
				| strap_n(2'(s), idx));
			en_wait(1000);
			bus(0, REG_FREQ, 0, 32'(BASE_KHZ / strap_n(2'(s), idx)));
			check(locked, 32'h0);
		end
		// Auto detect locks to a valid incoming clock
		run <= 1'b1;
		do_reset(2'h1, 2'h1, 5'h00);
		en_wait(1);
		wait_lock();
		check(locked, 32'h1);
		// Input mode rechecks at every enable
		do_reset(2'h0, 2'h0, 5'h00);
		en_wait(1);
		wait_lock();
		check(locked, 32'h1);
		check(sync_oe, 32'h0);
		en_pin <= 1'b0;
		run <= 1'b0;
		repeat (20) @(posedge hclk);
		en_wait(1100);
		check(locked, 32'h0);
		bus(0, REG_FREQ, 0, 32'(BASE_KHZ / N_LOW));
		// Out of range incoming clock counts as absent
		slow <= 1'b1;
		run <= 1'b1;
		do_reset(2'h1, 2'h2, 5'h00);
		en_wait(1100);
		check(locked, 32'h0);
		bus(0, REG_FREQ, 0, 32'(BASE_KHZ / N_HIGH));
		// Master mode drives its own 400 kHz clock out
		slow <= 1'b0;
		do_reset(2'h2, 2'h0, 5'h00);
		en_wait(20);
		check(sync_oe, 32'h1);
		check(locked, 32'h0);
		per(5 * N_MASTER);
		check(sync_out, 32'h1);
		bus(0, REG_STATUS, 0, (32'(BASE_DIV * N_MASTER) << STAT_PER_LSB)
			| (32'(LVL_HIGH) << STAT_MODE_LSB) | 32'h1);
		bus(0, REG_FREQ, 0, 32'(BASE_KHZ / N_MASTER));
		repeat (4) @(posedge hclk);
		test_done();
	end
endmodule : ssc_clock_select_test
`default_nettype wire
